// ---- core/cmh_pkg.sv ----
package cmh_pkg;
  // control token values on the link
  localparam logic [7:0] TOK_END = 8'h01;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_NAK = 8'h04;
  localparam logic [7:0] TOK_CFG_WR = 8'hC0;
  localparam logic [7:0] TOK_CFG_RD = 8'hC1;
  localparam logic [7:0] TOK_PER_WR = 8'h24;
  localparam logic [7:0] TOK_PER_RD = 8'h25;
  // destination patterns
  localparam logic [15:0] CFG_DEST_LOW = 16'hC30C;
  localparam logic [7:0] PER_DEST_LOW = 8'h02;
  localparam int DEST_NODE_POS = 16;
  localparam int DEST_PERIPH_POS = 8;
  // on a write, a return field whose low byte is all ones asks for no reply
  localparam logic [7:0] RET_NOACK = 8'hFF;
  localparam int RET_BYTES = 3;
  localparam int CFG_REG_BYTES = 2;
  localparam int CFG_DATA_BYTES = 4;
  // host command codes
  typedef enum logic [1:0] {
    CMH_OP_CFG_WR,
    CMH_OP_CFG_RD,
    CMH_OP_PER_WR,
    CMH_OP_PER_RD
  } cmh_op_t;
endpackage

// ---- core/cmh_link_if.sv ----
`timescale 1ns/1ps
interface cmh_link_if;
  // request tokens, requester to handler
  logic req_valid;
  logic req_ctrl;
  logic [7:0] req_data;
  logic [31:0] req_dest;
  logic req_ready;
  // reply tokens, handler to requester
  logic rsp_valid;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;
  logic rsp_ready;
  modport dev (
    input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
  modport host (
    output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
endinterface

// ---- core/cmh_device.sv ----
`timescale 1ns/1ps
module cmh_device #(
  parameter logic [15:0] NODE_ID = 16'h0001,
  parameter int CFG_DEPTH = 8,
  parameter int PER_DEPTH = 16,
  parameter int NUM_PERIPH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // link
  cmh_link_if.dev link,
  // user side
  output logic [31:0] cfg_word0_o,
  output logic [7:0] per_byte0_o,
  output logic busy_o
);
  localparam int PAW = (PER_DEPTH > 1) ? $clog2(PER_DEPTH) : 1;
  localparam int CAW = (CFG_DEPTH > 1) ? $clog2(CFG_DEPTH) : 1;

  typedef enum logic [3:0] {
    S_IDLE, S_RET, S_REG, S_SIZE, S_DATA, S_END, S_SKIP, S_HEAD, S_BODY, S_TAIL
  } cmh_dev_st_t;
  typedef enum logic [2:0] {K_CFG_WR, K_CFG_RD, K_PER_WR, K_PER_RD, K_BAD} cmh_kind_t;

  cmh_dev_st_t st_r;
  cmh_kind_t kind_r;
  logic [23:0] ret_r;
  logic [15:0] reg_r;
  logic [7:0] size_r;
  logic [7:0] cnt_r;
  logic [31:0] wdata_r;
  logic ok_r;
  logic wr_tok_r;
  logic [31:0] cfg_mem [CFG_DEPTH];
  logic [7:0] per_mem [PER_DEPTH];

  logic acc;
  logic is_end;
  logic is_wr;
  logic [15:0] reg_nxt;
  logic [8:0] per_span;

  assign acc = link.req_valid && link.req_ready;
  assign is_end = link.req_ctrl && (link.req_data == cmh_pkg::TOK_END);
  assign is_wr = wr_tok_r;
  assign reg_nxt = {reg_r[7:0], link.req_data};
  assign per_span = {1'b0, reg_r[7:0]} + {1'b0, link.req_data};

  function automatic cmh_kind_t decode(input logic [7:0] tok, input logic [31:0] dest);
    logic node_hit;
    logic cfg_hit;
    logic per_hit;
    node_hit = dest[31:cmh_pkg::DEST_NODE_POS] == NODE_ID;
    cfg_hit = node_hit && (dest[15:0] == cmh_pkg::CFG_DEST_LOW);
    per_hit = node_hit && (dest[7:0] == cmh_pkg::PER_DEST_LOW)
      && (32'(dest[15:cmh_pkg::DEST_PERIPH_POS]) < NUM_PERIPH);
    if (cfg_hit && tok == cmh_pkg::TOK_CFG_WR) begin
      decode = K_CFG_WR;
    end else if (cfg_hit && tok == cmh_pkg::TOK_CFG_RD) begin
      decode = K_CFG_RD;
    end else if (per_hit && tok == cmh_pkg::TOK_PER_WR) begin
      decode = K_PER_WR;
    end else if (per_hit && tok == cmh_pkg::TOK_PER_RD) begin
      decode = K_PER_RD;
    end else begin
      decode = K_BAD;
    end
  endfunction

  // request parse and reply sequencing
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= S_IDLE;
      kind_r <= K_BAD;
      ret_r <= 24'h000000;
      reg_r <= 16'h0000;
      size_r <= 8'h00;
      cnt_r <= 8'h00;
      ok_r <= 1'b0;
      wr_tok_r <= 1'b0;
    end else begin
      case (st_r)
        S_IDLE: begin
          // stray data tokens outside a message are dropped
          if (acc && link.req_ctrl) begin
            kind_r <= decode(link.req_data, link.req_dest);
            ok_r <= decode(link.req_data, link.req_dest) != K_BAD;
            // no-ack binds any write opener, routed or not: its sender is not listening
            wr_tok_r <= (link.req_data == cmh_pkg::TOK_CFG_WR) || (link.req_data == cmh_pkg::TOK_PER_WR);
            reg_r <= 16'h0000;
            cnt_r <= 8'(cmh_pkg::RET_BYTES - 1);
            st_r <= S_RET;
          end
        end
        S_RET, S_REG, S_SIZE, S_DATA: begin
          if (acc && link.req_ctrl) begin
            // truncated message ends in failure
            ok_r <= 1'b0;
            st_r <= is_end ? S_HEAD : S_SKIP;
          end else if (acc) begin
            cnt_r <= cnt_r - 8'h01;
            if (st_r == S_RET) begin
              ret_r <= {ret_r[15:0], link.req_data};
              if (cnt_r == 8'h00) begin
                st_r <= (kind_r == K_BAD) ? S_SKIP : S_REG;
                cnt_r <= (kind_r == K_CFG_WR || kind_r == K_CFG_RD) ? 8'(cmh_pkg::CFG_REG_BYTES - 1) : 8'h00;
              end
            end else if (st_r == S_REG) begin
              reg_r <= reg_nxt;
              if (cnt_r == 8'h00) begin
                if (kind_r == K_CFG_WR || kind_r == K_CFG_RD) begin
                  if (32'(reg_nxt) >= CFG_DEPTH) begin
                    ok_r <= 1'b0;
                  end
                  st_r <= (kind_r == K_CFG_WR) ? S_DATA : S_END;
                  cnt_r <= 8'(cmh_pkg::CFG_DATA_BYTES - 1);
                end else begin
                  st_r <= S_SIZE;
                end
              end
            end else if (st_r == S_SIZE) begin
              size_r <= link.req_data;
              if (32'(per_span) > PER_DEPTH) begin
                ok_r <= 1'b0;
              end
              cnt_r <= link.req_data - 8'h01;
              st_r <= (kind_r == K_PER_WR && link.req_data != 8'h00) ? S_DATA : S_END;
            end else begin
              if (kind_r == K_PER_WR) begin
                reg_r <= reg_r + 16'h0001;
              end
              if (cnt_r == 8'h00) begin
                st_r <= S_END;
              end
            end
          end
        end
        S_END, S_SKIP: begin
          if (acc && is_end) begin
            if (is_wr && ret_r[7:0] == cmh_pkg::RET_NOACK) begin
              st_r <= S_IDLE;
            end else begin
              st_r <= S_HEAD;
            end
          end else if (acc) begin
            ok_r <= 1'b0;
            st_r <= S_SKIP;
          end
        end
        S_HEAD: begin
          if (link.rsp_ready) begin
            cnt_r <= (kind_r == K_CFG_RD) ? 8'(cmh_pkg::CFG_DATA_BYTES - 1) : size_r - 8'h01;
            if (ok_r && (kind_r == K_CFG_RD || (kind_r == K_PER_RD && size_r != 8'h00))) begin
              st_r <= S_BODY;
            end else begin
              st_r <= S_TAIL;
            end
          end
        end
        S_BODY: begin
          if (link.rsp_ready) begin
            cnt_r <= cnt_r - 8'h01;
            if (kind_r == K_PER_RD) begin
              reg_r <= reg_r + 16'h0001;
            end
            if (cnt_r == 8'h00) begin
              st_r <= S_TAIL;
            end
          end
        end
        S_TAIL: begin
          if (link.rsp_ready) begin
            st_r <= S_IDLE;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // config word gathering and read-out shift
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdata_r <= 32'h00000000;
    end else if (st_r == S_DATA && acc && !link.req_ctrl && kind_r == K_CFG_WR) begin
      wdata_r <= {wdata_r[23:0], link.req_data};
    end else if (st_r == S_END && acc && is_end && kind_r == K_CFG_RD && ok_r) begin
      wdata_r <= cfg_mem[reg_r[CAW-1:0]];
    end else if (st_r == S_BODY && link.rsp_ready) begin
      wdata_r <= {wdata_r[23:0], 8'h00};
    end
  end

  // config words commit only on a clean closing token
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfg_mem[i] <= 32'h00000000;
      end
    end else if (st_r == S_END && acc && is_end && kind_r == K_CFG_WR && ok_r) begin
      cfg_mem[reg_r[CAW-1:0]] <= wdata_r;
    end
  end

  // peripheral bytes land as they arrive, range already checked
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < PER_DEPTH; i++) begin
        per_mem[i] <= 8'h00;
      end
    end else if (st_r == S_DATA && acc && !link.req_ctrl && kind_r == K_PER_WR && ok_r) begin
      per_mem[reg_r[PAW-1:0]] <= link.req_data;
    end
  end

  always_comb begin
    link.req_ready = (st_r != S_HEAD) && (st_r != S_BODY) && (st_r != S_TAIL);
    link.rsp_valid = !link.req_ready;
    link.rsp_ctrl = st_r != S_BODY;
    link.rsp_dest = ret_r;
    if (st_r == S_HEAD) begin
      link.rsp_data = ok_r ? cmh_pkg::TOK_ACK : cmh_pkg::TOK_NAK;
    end else if (st_r == S_BODY) begin
      link.rsp_data = (kind_r == K_CFG_RD) ? wdata_r[31:24] : per_mem[reg_r[PAW-1:0]];
    end else begin
      link.rsp_data = cmh_pkg::TOK_END;
    end
  end

  assign cfg_word0_o = cfg_mem[0];
  assign per_byte0_o = per_mem[0];
  assign busy_o = st_r != S_IDLE;
endmodule

// ---- core/cmh_host.sv ----
`timescale 1ns/1ps
module cmh_host #(
  parameter int MAX_PER_BYTES = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // link
  cmh_link_if.host link,
  // command port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire cmh_pkg::cmh_op_t cmd_op_i,
  input wire logic [31:0] cmd_dest_i,
  input wire logic [23:0] cmd_ret_i,
  input wire logic [15:0] cmd_reg_i,
  input wire logic [7:0] cmd_size_i,
  input wire logic [31:0] cmd_wdata_i,
  // result
  output logic done_o,
  output logic ok_o,
  output logic [31:0] rdata_o
);
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} cmh_host_st_t;

  cmh_host_st_t st_r;
  cmh_pkg::cmh_op_t op_r;
  logic [31:0] dest_r;
  logic [23:0] ret_r;
  logic [15:0] reg_r;
  logic [7:0] size_r;
  logic [31:0] wdata_r;
  logic [7:0] pos_r;
  logic got_head_r;

  logic is_cfg;
  logic is_wr;
  logic [7:0] n_reg;
  logic [7:0] n_data;
  logic [7:0] last_pos;
  logic [8:0] tok;

  assign is_cfg = (op_r == cmh_pkg::CMH_OP_CFG_WR) || (op_r == cmh_pkg::CMH_OP_CFG_RD);
  assign is_wr = (op_r == cmh_pkg::CMH_OP_CFG_WR) || (op_r == cmh_pkg::CMH_OP_PER_WR);
  assign n_reg = is_cfg ? 8'(cmh_pkg::CFG_REG_BYTES) : 8'h02; // periph: register then size
  assign n_data = !is_wr ? 8'h00 : (is_cfg ? 8'(cmh_pkg::CFG_DATA_BYTES) : size_r);
  assign last_pos = 8'(1 + cmh_pkg::RET_BYTES) + n_reg + n_data;

  // token at pos_r as {ctrl, value}, fields most significant first
  always_comb begin
    logic [7:0] k;
    k = 8'h00;
    if (pos_r == 8'h00) begin
      case (op_r)
        cmh_pkg::CMH_OP_CFG_WR: tok = {1'b1, cmh_pkg::TOK_CFG_WR};
        cmh_pkg::CMH_OP_CFG_RD: tok = {1'b1, cmh_pkg::TOK_CFG_RD};
        cmh_pkg::CMH_OP_PER_WR: tok = {1'b1, cmh_pkg::TOK_PER_WR};
        default: tok = {1'b1, cmh_pkg::TOK_PER_RD};
      endcase
    end else if (pos_r <= 8'(cmh_pkg::RET_BYTES)) begin
      k = 8'(cmh_pkg::RET_BYTES) - pos_r;
      tok = {1'b0, 8'(ret_r >> {k[4:0], 3'b000})};
    end else if (pos_r < 8'(1 + cmh_pkg::RET_BYTES) + n_reg) begin
      k = pos_r - 8'(1 + cmh_pkg::RET_BYTES);
      if (is_cfg) begin
        tok = {1'b0, (k == 8'h00) ? reg_r[15:8] : reg_r[7:0]};
      end else begin
        tok = {1'b0, (k == 8'h00) ? reg_r[7:0] : size_r};
      end
    end else if (pos_r < last_pos) begin
      k = last_pos - pos_r - 8'h01;
      tok = {1'b0, 8'(wdata_r >> {k[4:0], 3'b000})};
    end else begin
      tok = {1'b1, cmh_pkg::TOK_END};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= H_IDLE;
      op_r <= cmh_pkg::CMH_OP_CFG_RD;
      dest_r <= 32'h00000000;
      ret_r <= 24'h000000;
      reg_r <= 16'h0000;
      size_r <= 8'h00;
      wdata_r <= 32'h00000000;
      pos_r <= 8'h00;
      got_head_r <= 1'b0;
      done_o <= 1'b0;
      ok_o <= 1'b0;
      rdata_o <= 32'h00000000;
    end else begin
      done_o <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (cmd_valid_i) begin
            op_r <= cmd_op_i;
            dest_r <= cmd_dest_i;
            ret_r <= cmd_ret_i;
            reg_r <= cmd_reg_i;
            // longer peripheral transfers are clipped to what one word holds
            size_r <= (32'(cmd_size_i) > MAX_PER_BYTES) ? 8'(MAX_PER_BYTES) : cmd_size_i;
            wdata_r <= cmd_wdata_i;
            pos_r <= 8'h00;
            st_r <= H_SEND;
          end
        end
        H_SEND: begin
          if (link.req_ready) begin
            pos_r <= pos_r + 8'h01;
            if (pos_r == last_pos) begin
              got_head_r <= 1'b0;
              rdata_o <= 32'h00000000;
              if (is_wr && ret_r[7:0] == cmh_pkg::RET_NOACK) begin
                st_r <= H_IDLE;
                ok_o <= 1'b1;
                done_o <= 1'b1;
              end else begin
                st_r <= H_WAIT;
              end
            end
          end
        end
        H_WAIT: begin
          if (link.rsp_valid) begin
            if (!got_head_r) begin
              got_head_r <= 1'b1;
              ok_o <= link.rsp_data == cmh_pkg::TOK_ACK;
            end else if (!link.rsp_ctrl) begin
              rdata_o <= {rdata_o[23:0], link.rsp_data};
            end else if (link.rsp_data == cmh_pkg::TOK_END) begin
              done_o <= 1'b1;
              st_r <= H_IDLE;
            end
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  assign cmd_ready_o = st_r == H_IDLE;
  assign link.req_valid = st_r == H_SEND;
  assign link.req_ctrl = tok[8];
  assign link.req_data = tok[7:0];
  assign link.req_dest = dest_r;
  assign link.rsp_ready = st_r == H_WAIT;
endmodule

// ---- tb/cmh_link_assertions.sv ----
`timescale 1ns/1ps
module cmh_link_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // request link
  input wire logic req_valid,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic [31:0] req_dest,
  input wire logic req_ready,
  // reply link
  input wire logic rsp_valid,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest,
  input wire logic rsp_ready
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [23:0] ret_r;
  logic [1:0] cnt_r;
  logic wr_r;
  wire req_take = req_valid && req_ready;
  wire close_take = req_take && req_ctrl && req_data == 8'h01;
  // only the three bytes after an opener form the return field
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ret_r <= '0;
      cnt_r <= '0;
      wr_r <= 1'b0;
    end else if (req_take && req_ctrl) begin
      cnt_r <= 2'h0;
      // the closing token must not wipe what the opener said
      if (req_data != 8'h01) begin
        wr_r <= req_data == 8'hC0 || req_data == 8'h24;
      end
    end else if (req_take && cnt_r != 2'h3) begin
      ret_r <= {ret_r[15:0], req_data};
      cnt_r <= cnt_r + 2'h1;
    end
  end
  a_reply_head_code: assert property ($rose(rsp_valid)
    |-> rsp_ctrl && (rsp_data == 8'h03 || rsp_data == 8'h04))
    else $error("reply does not open with ack or nak");
  a_nak_then_end: assert property (rsp_valid && rsp_ready && rsp_ctrl && rsp_data == 8'h04
    |=> rsp_valid && rsp_ctrl && rsp_data == 8'h01)
    else $error("nak not followed by end token");
  a_reply_follows_close: assert property ($rose(rsp_valid) |-> $past(close_take))
    else $error("reply not right after closing token");
  a_reply_blocks_req: assert property (rsp_valid |-> !req_ready)
    else $error("request taken during reply");
  a_reply_ends_bounded: assert property ($rose(rsp_valid)
    |-> ##[1:40] (rsp_valid && rsp_ready && rsp_ctrl && rsp_data == 8'h01))
    else $error("reply not closed in time");
  a_reply_holds: assert property (rsp_valid && !rsp_ready
    |=> rsp_valid && $stable(rsp_data) && $stable(rsp_ctrl) && $stable(rsp_dest))
    else $error("reply token changed before taken");
  a_req_holds: assert property (req_valid && !req_ready
    |=> req_valid && $stable(req_data) && $stable(req_ctrl))
    else $error("request token changed before taken");
  a_reply_dest_match: assert property (rsp_valid |-> rsp_dest == ret_r)
    else $error("reply not addressed to return field");
  a_noack_silent: assert property ($rose(rsp_valid) |-> !(wr_r && ret_r[7:0] == 8'hFF))
    else $error("reply sent for no-ack write");
endmodule

// ---- tb/config_message_access_handler_tb.sv ----
`timescale 1ns/1ps
module config_message_access_handler_tb;
  localparam logic [31:0] CFGD = 32'h0001C30C;
  localparam logic [31:0] PERD = 32'h00010002;
  localparam logic [23:0] RET = 24'h000102;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  cmh_pkg::cmh_op_t cmd_op_i = cmh_pkg::CMH_OP_CFG_WR;
  logic [31:0] cmd_dest_i = '0;
  logic [23:0] cmd_ret_i = '0;
  logic [15:0] cmd_reg_i = '0;
  logic [7:0] cmd_size_i = '0;
  logic [31:0] cmd_wdata_i = '0;
  logic cmd_ready_o, done_o, ok_o, busy_o;
  logic [31:0] rdata_o, cfg_word0_o;
  logic [7:0] per_byte0_o;
  logic [31:0] cfg_m[8];
  logic [7:0] per_m[16];
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;
  cmh_link_if link_i ();
  cmh_device cmh_device_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_i.dev), .cfg_word0_o(cfg_word0_o),
    .per_byte0_o(per_byte0_o), .busy_o(busy_o));
  cmh_host cmh_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_i.host), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_dest_i(cmd_dest_i), .cmd_ret_i(cmd_ret_i),
    .cmd_reg_i(cmd_reg_i), .cmd_size_i(cmd_size_i), .cmd_wdata_i(cmd_wdata_i), .done_o(done_o), .ok_o(ok_o),
    .rdata_o(rdata_o));
  cmh_link_assertions cmh_link_assertions_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid(link_i.req_valid),
    .req_ctrl(link_i.req_ctrl), .req_data(link_i.req_data), .req_dest(link_i.req_dest),
    .req_ready(link_i.req_ready), .rsp_valid(link_i.rsp_valid), .rsp_ctrl(link_i.rsp_ctrl),
    .rsp_data(link_i.rsp_data), .rsp_dest(link_i.rsp_dest), .rsp_ready(link_i.rsp_ready));
  task automatic report_and_stop();
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // a hang here is far past the thousand or so cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  function automatic logic exp_ok(cmh_pkg::cmh_op_t op, logic [31:0] dest, logic [15:0] rg, logic [7:0] sz);
    if (op == cmh_pkg::CMH_OP_CFG_WR || op == cmh_pkg::CMH_OP_CFG_RD) return dest == CFGD && rg < 16'h0008;
    return dest == PERD && 32'(rg[7:0]) + 32'(sz) <= 32'h10;
  endfunction
  function automatic logic [31:0] exp_rd(cmh_pkg::cmh_op_t op, logic [15:0] rg, logic [7:0] sz);
    logic [31:0] v;
    v = '0;
    if (op == cmh_pkg::CMH_OP_CFG_RD) return cfg_m[rg[2:0]];
    for (int k = 0; k < sz; k++) v = {v[23:0], per_m[rg[3:0] + k]};
    return v;
  endfunction
  task automatic run(cmh_pkg::cmh_op_t op, logic [31:0] dest, logic [23:0] ret, logic [15:0] rg, logic [7:0] sz,
    logic [31:0] wd);
    logic ok_e;
    logic wr;
    logic [31:0] mask;
    ok_e = exp_ok(op, dest, rg, sz);
    wr = op == cmh_pkg::CMH_OP_CFG_WR || op == cmh_pkg::CMH_OP_PER_WR;
    // a config read always returns a whole word, whatever size was asked
    mask = (op == cmh_pkg::CMH_OP_CFG_RD || sz == 8'h04) ? 32'hFFFFFFFF : (32'h1 << (8 * sz)) - 32'h1;
    while (cmd_ready_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    {cmd_op_i, cmd_dest_i, cmd_ret_i, cmd_reg_i, cmd_size_i, cmd_wdata_i} = {op, dest, ret, rg, sz, wd};
    cmd_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
    cmd_valid_i = 1'b0;
    for (int i = 0; i < 200 && done_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk_bit(done_o, 1'b1, "done");
    chk_bit(busy_o, 1'b0, "busy after done");
    if (!(wr && ret[7:0] == 8'hFF)) chk_bit(ok_o, ok_e, "ok flag");
    if (!wr && ok_e) chk_word(rdata_o & mask, exp_rd(op, rg, sz) & mask, "read data");
    if (wr && ok_e && op == cmh_pkg::CMH_OP_CFG_WR) cfg_m[rg[2:0]] = wd;
    if (wr && ok_e && op == cmh_pkg::CMH_OP_PER_WR) begin
      for (int k = 0; k < sz; k++) per_m[rg[3:0] + k] = wd[8 * (sz - 1 - k) +: 8];
    end
    chk_word(cfg_word0_o, cfg_m[0], "config word 0");
    chk_word({24'h0, per_byte0_o}, {24'h0, per_m[0]}, "periph byte 0");
  endtask
  initial begin
    foreach (cfg_m[i]) cfg_m[i] = '0;
    foreach (per_m[i]) per_m[i] = '0;
    repeat (16) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    void'($urandom(61405));
    run(cmh_pkg::CMH_OP_CFG_WR, CFGD, RET, 16'h0000, 8'h00, 32'hA55A0FF0);
    run(cmh_pkg::CMH_OP_CFG_WR, CFGD, RET, 16'h0007, 8'h00, 32'h12345678);
    run(cmh_pkg::CMH_OP_CFG_RD, CFGD, RET, 16'h0007, 8'h04, 32'h0);
    run(cmh_pkg::CMH_OP_CFG_WR, CFGD, RET, 16'h0008, 8'h00, 32'hFFFFFFFF);
    run(cmh_pkg::CMH_OP_CFG_RD, CFGD, RET, 16'h0008, 8'h04, 32'h0);
    run(cmh_pkg::CMH_OP_CFG_WR, 32'h0002C30C, RET, 16'h0000, 8'h00, 32'h0);
    run(cmh_pkg::CMH_OP_CFG_WR, 32'h0002C30C, 24'h0001FF, 16'h0000, 8'h00, 32'h0);
    run(cmh_pkg::CMH_OP_CFG_RD, CFGD, 24'h0001FF, 16'h0000, 8'h04, 32'h0);
    run(cmh_pkg::CMH_OP_PER_WR, PERD, RET, 16'h000C, 8'h04, 32'hDEADBEEF);
    run(cmh_pkg::CMH_OP_PER_RD, PERD, RET, 16'h000C, 8'h04, 32'h0);
    run(cmh_pkg::CMH_OP_PER_WR, PERD, RET, 16'h000D, 8'h04, 32'h01020304);
    run(cmh_pkg::CMH_OP_PER_WR, 32'h00010102, RET, 16'h0000, 8'h01, 32'h77);
    run(cmh_pkg::CMH_OP_PER_WR, PERD, RET, 16'h0000, 8'h00, 32'h0);
    run(cmh_pkg::CMH_OP_PER_WR, PERD, 24'h0001FF, 16'h0000, 8'h02, 32'hBEEF);
    run(cmh_pkg::CMH_OP_PER_RD, PERD, RET, 16'h0000, 8'h02, 32'h0);
    run(cmh_pkg::CMH_OP_CFG_WR, CFGD, 24'h0003FF, 16'h0000, 8'h00, 32'hC001D00D);
    $display("test corners done");
    for (int n = 0; n < 60; n++) begin
      run(cmh_pkg::cmh_op_t'($urandom_range(0, 3)), $urandom_range(0, 7) == 0 ? 32'h00030002 :
        ($urandom_range(0, 1) ? CFGD : PERD), {16'($urandom_range(0, 65535)), 8'($urandom_range(0, 254))},
        16'($urandom_range(0, 17)), 8'($urandom_range(0, 4)), $urandom);
    end
    $display("test random done");
    report_and_stop();
  end
endmodule
